/* File: common/flash_seq_params.svh */
// Constants for the flash self-program sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define PTR_W 22
`define PTR_INC_W 21
`define BLK_LSB 6
`define HOLD_N 64
`define HOLD_IDX_W 6
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define HOLD_ERASED 8'hff
`define CTRL_PGM_SEL 7
`define CTRL_CFG_SEL 6
`define CTRL_ERASE 4
`define CTRL_ABORT 3
`define CTRL_PEN 2
`define CTRL_LAUNCH 1
`define PROG_TIME_US 2000
`define CLK_MHZ 20
`define TMR_W 16
`endif

/* File: common/flash_seq_pkg.sv */
// Types for the flash self-program sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_KEY1 = 2'b01,
    ST_ARMED = 2'b11,
    ST_BUSY = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    PTR_KEEP = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC = 2'b11
  } ptr_mode_t;
endpackage

/* File: verilog/flash_self_program_sequencer.sv */
// Flash self-program sequencer: table reads/writes, unlock, block erase and program
// What this block does
// - Table reads return exactly one program memory byte each
// - Table read copies pointed byte into table_latch, pointer optionally updated
// - Pointer bit zero picks high or low byte of the array word
// - Erase always clears a whole 64 byte block, never one word
// - Erase block comes from pointer bits 21:6, bits 5:0 ignored
// - Long write starts only after keys 55h, 0AAh, then launch_bit
// - CPU is stalled for about 2 ms during erase or program
// - Long write ends when the programming timer expires, or early on reset
// - Programming writes only the enabled bytes of the 64 byte block
// - One holding register per block byte; table writes touch only these
// - Block programs only after program configuration and unlock sequence
// - Holding registers return to FFh on reset and after each program, not after an erase
// - Holding byte left at FFh leaves the array byte unchanged
// - Hardware clears launch_bit at completion; software can only set it
// - Done flag set on completion, held until software clears it
// - Abort flag set on plain reset mid-write or improper launch; selects kept
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  input wire logic ptr_wr_in,
  input wire logic [`PTR_W-1:0] ptr_wdata_in,
  input wire logic latch_wr_in,
  input wire logic [7:0] latch_wdata_in,
  input wire logic tbl_rd_in,
  input wire logic tbl_wr_in,
  input wire logic [1:0] tbl_mode_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_wdata_in,
  input wire logic done_clr_in,
  input wire logic [15:0] arr_rdata_in,
  output logic [`PTR_W-1:0] table_pointer_out,
  output logic [7:0] table_latch_out,
  output logic [7:0] memory_control_out,
  output logic nvm_done_flag_out,
  output logic cpu_stall_out,
  output logic arr_rd_out,
  output logic arr_erase_out,
  output logic arr_prog_out,
  output logic [`PTR_W-1:0] arr_addr_out,
  output logic [8*`HOLD_N-1:0] arr_wdata_out,
  output logic [`HOLD_N-1:0] arr_byte_en_out
);

  // ==========================================================
  // Unlock, launch and timer
  // ==========================================================
  localparam logic [`TMR_W-1:0] TMR_LOAD = `TMR_W'(PROG_CYCLES - 1);

  seq_state_t state_r, state_nxt;
  logic [`TMR_W-1:0] tmr_r, tmr_nxt;
  logic pgm_sel_r, pgm_sel_nxt;
  logic cfg_sel_r, cfg_sel_nxt;
  logic erase_r, erase_nxt;
  logic abort_r, abort_nxt;
  logic pen_r, pen_nxt;
  logic launch_r, launch_nxt;
  logic done_r, done_nxt;
  logic arr_erase_r, arr_erase_nxt;
  logic arr_prog_r, arr_prog_nxt;
  logic finish;
  logic other_wr;
  logic cpu_ok;

  // Stalled CPU cannot issue accesses; ignore any that leak through, except done clears
  assign cpu_ok = (state_r != ST_BUSY);
  assign finish = (state_r == ST_BUSY) && (tmr_r == '0);
  assign other_wr = ptr_wr_in | latch_wr_in | tbl_wr_in |
                    (ctrl_wr_in & ~ctrl_wdata_in[`CTRL_LAUNCH]);

  // Next state of the long write sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    pgm_sel_nxt = pgm_sel_r;
    cfg_sel_nxt = cfg_sel_r;
    erase_nxt = erase_r;
    abort_nxt = abort_r;
    pen_nxt = pen_r;
    launch_nxt = launch_r;
    done_nxt = done_r;
    arr_erase_nxt = arr_erase_r;
    arr_prog_nxt = arr_prog_r;
    if (done_clr_in) begin
      done_nxt = 1'b0;
    end
    if (cpu_ok && ctrl_wr_in) begin
      pgm_sel_nxt = ctrl_wdata_in[`CTRL_PGM_SEL];
      cfg_sel_nxt = ctrl_wdata_in[`CTRL_CFG_SEL];
      erase_nxt = ctrl_wdata_in[`CTRL_ERASE];
      abort_nxt = ctrl_wdata_in[`CTRL_ABORT];
      pen_nxt = ctrl_wdata_in[`CTRL_PEN];
    end
    unique case (state_r)
      ST_IDLE: begin
        if (key_wr_in && key_wdata_in == `KEY_FIRST) begin
          state_nxt = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (key_wr_in && key_wdata_in == `KEY_SECOND) begin
          state_nxt = ST_ARMED;
        end else if (key_wr_in && key_wdata_in == `KEY_FIRST) begin
          state_nxt = ST_KEY1;
        end else if (key_wr_in || other_wr || ctrl_wr_in) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ARMED: begin
        // A fresh first key always restarts the unlock
        if (key_wr_in && key_wdata_in == `KEY_FIRST) begin
          state_nxt = ST_KEY1;
        end else if (key_wr_in || other_wr) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BUSY: begin
        tmr_nxt = tmr_r - `TMR_W'(1);
        if (finish) begin
          state_nxt = ST_IDLE;
          launch_nxt = 1'b0;
          erase_nxt = 1'b0;
          done_nxt = 1'b1;
          arr_erase_nxt = 1'b0;
          arr_prog_nxt = 1'b0;
        end
      end
    endcase
    // Launch only counts straight after the keys, with writes enabled
    if (cpu_ok && ctrl_wr_in && ctrl_wdata_in[`CTRL_LAUNCH]) begin
      if (state_r == ST_ARMED && ctrl_wdata_in[`CTRL_PEN] &&
          ctrl_wdata_in[`CTRL_PGM_SEL] && !ctrl_wdata_in[`CTRL_CFG_SEL]) begin
        state_nxt = ST_BUSY;
        launch_nxt = 1'b1;
        tmr_nxt = TMR_LOAD;
        arr_erase_nxt = ctrl_wdata_in[`CTRL_ERASE];
        arr_prog_nxt = !ctrl_wdata_in[`CTRL_ERASE];
      end else begin
        state_nxt = ST_IDLE;
        abort_nxt = 1'b1;
      end
    end
  end

  // Abort and space selects survive a plain reset so software can trace the lost write
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || por_in) begin
      state_r <= ST_IDLE;
      tmr_r <= '0;
      pgm_sel_r <= por_in ? 1'b0 : pgm_sel_r;
      cfg_sel_r <= por_in ? 1'b0 : cfg_sel_r;
      erase_r <= 1'b0;
      abort_r <= por_in ? 1'b0 : (abort_r | (state_r == ST_BUSY));
      pen_r <= 1'b0;
      launch_r <= 1'b0;
      done_r <= 1'b0;
      arr_erase_r <= 1'b0;
      arr_prog_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      pgm_sel_r <= pgm_sel_nxt;
      cfg_sel_r <= cfg_sel_nxt;
      erase_r <= erase_nxt;
      abort_r <= abort_nxt;
      pen_r <= pen_nxt;
      launch_r <= launch_nxt;
      done_r <= done_nxt;
      arr_erase_r <= arr_erase_nxt;
      arr_prog_r <= arr_prog_nxt;
    end
  end

  // ==========================================================
  // Pointer, latch and table reads
  // ==========================================================
  logic [`PTR_W-1:0] ptr_r, ptr_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic rd_hi_r, rd_hi_nxt;
  logic arr_rd_r, arr_rd_nxt;
  logic [`PTR_W-1:0] addr_r, addr_nxt;
  logic [`PTR_W-1:0] eff_ptr;
  logic [`PTR_INC_W-1:0] low_inc;
  logic [`PTR_INC_W-1:0] low_dec;
  logic tbl_op;

  // Only the low 21 bits step; the top bit stays put
  assign low_inc = ptr_r[`PTR_INC_W-1:0] + `PTR_INC_W'(1);
  assign low_dec = ptr_r[`PTR_INC_W-1:0] - `PTR_INC_W'(1);
  assign tbl_op = cpu_ok && (tbl_rd_in || tbl_wr_in);
  assign eff_ptr = (ptr_mode_t'(tbl_mode_in) == PTR_PRE_INC) ?
                   {ptr_r[`PTR_W-1], low_inc} : ptr_r;

  // Next pointer, latch and array read request
  always_comb begin
    ptr_nxt = ptr_r;
    latch_nxt = latch_r;
    rd_pend_nxt = 1'b0;
    rd_hi_nxt = rd_hi_r;
    arr_rd_nxt = 1'b0;
    addr_nxt = addr_r;
    if (cpu_ok && ptr_wr_in) begin
      ptr_nxt = ptr_wdata_in;
    end
    if (cpu_ok && latch_wr_in) begin
      latch_nxt = latch_wdata_in;
    end
    if (tbl_op) begin
      unique case (ptr_mode_t'(tbl_mode_in))
        PTR_KEEP: ptr_nxt = ptr_r;
        PTR_POST_INC: ptr_nxt = {ptr_r[`PTR_W-1], low_inc};
        PTR_POST_DEC: ptr_nxt = {ptr_r[`PTR_W-1], low_dec};
        PTR_PRE_INC: ptr_nxt = {ptr_r[`PTR_W-1], low_inc};
      endcase
    end
    if (cpu_ok && tbl_rd_in) begin
      arr_rd_nxt = 1'b1;
      addr_nxt = eff_ptr;
      rd_hi_nxt = eff_ptr[0];
      rd_pend_nxt = 1'b1;
    end
    if (rd_pend_r) begin
      latch_nxt = rd_hi_r ? arr_rdata_in[15:8] : arr_rdata_in[7:0];
    end
    // Long writes point at the block base; low bits never reach the array
    if (state_r == ST_ARMED && state_nxt == ST_BUSY) begin
      addr_nxt = {ptr_r[`PTR_W-1:`BLK_LSB], `BLK_LSB'(0)};
    end
  end

  // Pointer and latch registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || por_in) begin
      ptr_r <= '0;
      latch_r <= '0;
      rd_pend_r <= 1'b0;
      rd_hi_r <= 1'b0;
      arr_rd_r <= 1'b0;
      addr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
      latch_r <= latch_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_hi_r <= rd_hi_nxt;
      arr_rd_r <= arr_rd_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ==========================================================
  // Holding registers
  // ==========================================================
  logic [`HOLD_IDX_W-1:0] hold_idx;
  logic hold_clear;

  // Table writes land in the holding bank by the pointer's low six bits
  assign hold_idx = eff_ptr[`HOLD_IDX_W-1:0];
  assign hold_clear = finish && arr_prog_r;

  genvar gi;
  generate
    for (gi = 0; gi < `HOLD_N; gi++) begin : g_hold
      logic [7:0] hold_r, hold_nxt;
      logic en_r, en_nxt;

      // One byte of the write block
      always_comb begin
        hold_nxt = hold_r;
        if (hold_clear) begin
          hold_nxt = `HOLD_ERASED;
        end else if (cpu_ok && tbl_wr_in && hold_idx == `HOLD_IDX_W'(gi)) begin
          hold_nxt = latch_r;
        end
        en_nxt = (hold_nxt != `HOLD_ERASED);
      end

      // Reset leaves the byte erased so it cannot disturb the array
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || por_in) begin
          hold_r <= `HOLD_ERASED;
          en_r <= 1'b0;
        end else begin
          hold_r <= hold_nxt;
          en_r <= en_nxt;
        end
      end

      assign arr_wdata_out[8*gi +: 8] = hold_r;
      assign arr_byte_en_out[gi] = en_r;
    end
  endgenerate

  // ==========================================================
  // Outputs
  // ==========================================================
  assign table_pointer_out = ptr_r;
  assign table_latch_out = latch_r;
  assign memory_control_out = {pgm_sel_r, cfg_sel_r, 1'b0, erase_r,
                               abort_r, pen_r, launch_r, 1'b0};
  assign nvm_done_flag_out = done_r;
  // Launch bit stands for exactly the long write, so it drives the stall directly
  assign cpu_stall_out = launch_r;
  assign arr_rd_out = arr_rd_r;
  assign arr_erase_out = arr_erase_r;
  assign arr_prog_out = arr_prog_r;
  assign arr_addr_out = addr_r;

endmodule

/* File: verif/flash_array_model.sv */
// Behavioural flash array facing the sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_array_model (
  input wire logic clk_sys_in,
  input wire logic arr_rd_out,
  input wire logic arr_erase_out,
  input wire logic arr_prog_out,
  input wire logic [`PTR_W-1:0] arr_addr_out,
  input wire logic [8*`HOLD_N-1:0] arr_wdata_out,
  input wire logic [`HOLD_N-1:0] arr_byte_en_out,
  output logic [15:0] arr_rdata_in
);
  logic [7:0] mem [0:255];
  logic [15:0] last_r;
  // Word w starts as {~w, w}; only four blocks are modelled
  initial begin
    last_r = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = i[0] ? ~8'(i >> 1) : 8'(i >> 1);
  end
  // Re-applied every busy cycle: erase and AND-programming are idempotent
  always @(posedge clk_sys_in) begin
    if (arr_rd_out) last_r <= arr_rdata_in;
    for (int b = 0; b < 64; b++) begin
      if (arr_erase_out) mem[{arr_addr_out[7:6], 6'(b)}] <= 8'hff;
      if (arr_prog_out && arr_byte_en_out[b])
        mem[{arr_addr_out[7:6], 6'(b)}] <=
          mem[{arr_addr_out[7:6], 6'(b)}] & arr_wdata_out[8*b +: 8];
    end
  end
  // Outside a read the bus shows the inverse, so a stale byte never matches
  assign arr_rdata_in = arr_rd_out ? {mem[{arr_addr_out[7:1], 1'b1}],
    mem[{arr_addr_out[7:1], 1'b0}]} : ~last_r;
endmodule

/* File: verif/flash_seq_asserts.sv */
// Port checks for the flash self-program sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_seq_asserts #(
  parameter int PROG_CYCLES = 40000
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  input wire logic ptr_wr_in,
  input wire logic latch_wr_in,
  input wire logic tbl_rd_in,
  input wire logic tbl_wr_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_wdata_in,
  input wire logic done_clr_in,
  input wire logic [15:0] arr_rdata_in,
  input wire logic [`PTR_W-1:0] table_pointer_out,
  input wire logic [7:0] table_latch_out,
  input wire logic [7:0] memory_control_out,
  input wire logic nvm_done_flag_out,
  input wire logic cpu_stall_out,
  input wire logic arr_rd_out,
  input wire logic arr_erase_out,
  input wire logic arr_prog_out,
  input wire logic [`PTR_W-1:0] arr_addr_out,
  input wire logic [8*`HOLD_N-1:0] arr_wdata_out,
  input wire logic [`HOLD_N-1:0] arr_byte_en_out
);
  logic [15:0] stall_cnt_r, stall_cnt_nxt;
  logic quiet;
  logic rst_d_r;
  // Stall length is far too long for a repetition count
  always_comb stall_cnt_nxt = cpu_stall_out ? stall_cnt_r + 16'h1 : 16'h0;
  always_ff @(posedge clk_sys_in) stall_cnt_r <= stall_cnt_nxt;
  assign quiet = !(ptr_wr_in || latch_wr_in || tbl_wr_in || ctrl_wr_in || key_wr_in);
  default clocking @(posedge clk_sys_in); endclocking
  // Reset drops on a clock edge; keep checks off for that edge as well
  always_ff @(posedge clk_sys_in) rst_d_r <= sys_rst_in || por_in;
  default disable iff (sys_rst_in || por_in || rst_d_r);
  // ==========================================
  // Unlock and launch
  sequence keys_s;
    key_wr_in && key_wdata_in == `KEY_FIRST && !cpu_stall_out ##1 quiet
      ##1 key_wr_in && key_wdata_in == `KEY_SECOND ##1 quiet;
  endsequence
  sequence good_launch_s;
    ctrl_wr_in && ctrl_wdata_in[7:6] == 2'b10 && ctrl_wdata_in[2:1] == 2'b11;
  endsequence
  AST_UNLOCK_LAUNCH: assert property (keys_s ##1 good_launch_s |=> cpu_stall_out)
    else $error("launch not taken");
  AST_BAD_LAUNCH: assert property (ctrl_wr_in && ctrl_wdata_in[1] && !ctrl_wdata_in[2] &&
    !cpu_stall_out |=> !cpu_stall_out && memory_control_out[3]) else $error("bad launch taken");
  // A stall cut short by reset is an abort, not a completed write
  AST_STALL_LENGTH: assert property ($fell(cpu_stall_out) && !rst_d_r |->
    stall_cnt_r == PROG_CYCLES) else $error("stall length wrong");
  AST_STALL_BOUND: assert property (stall_cnt_r <= PROG_CYCLES)
    else $error("stall overrun");
  AST_DONE_AT_END: assert property ($fell(cpu_stall_out) && !rst_d_r |->
    nvm_done_flag_out && !memory_control_out[1] && !arr_erase_out && !arr_prog_out)
    else $error("end state wrong");
  AST_DONE_HOLDS: assert property (nvm_done_flag_out && !done_clr_in |=>
    nvm_done_flag_out) else $error("done flag dropped");
  AST_ERASE_BLOCK: assert property (arr_erase_out |->
    arr_addr_out == {table_pointer_out[21:6], 6'h00}) else $error("erase address wrong");
  AST_READ_BYTE: assert property (tbl_rd_in && !cpu_stall_out |=>
    arr_rd_out ##1 table_latch_out == ($past(arr_addr_out[0]) ? $past(arr_rdata_in[15:8]) :
    $past(arr_rdata_in[7:0]))) else $error("read byte wrong");
  AST_HOLD_RESTORE: assert property ($fell(arr_prog_out) |-> arr_byte_en_out == '0 &&
    &arr_wdata_out) else $error("holding not restored");
  AST_BYTE_EN0: assert property (arr_byte_en_out[0] == (arr_wdata_out[7:0] != 8'hff))
    else $error("byte enable wrong");
endmodule
bind flash_self_program_sequencer flash_seq_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

/* File: verif/tb.sv */
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module tb;
  localparam int PC = 20;
  logic clk_sys_in = 0, sys_rst_in = 1, por_in = 1, done_clr_in = 0;
  logic ptr_wr_in = 0, latch_wr_in = 0, tbl_rd_in = 0;
  logic tbl_wr_in = 0, ctrl_wr_in = 0, key_wr_in = 0;
  logic [`PTR_W-1:0] ptr_wdata_in = '0, table_pointer_out, arr_addr_out;
  logic [7:0] latch_wdata_in = '0, ctrl_wdata_in = '0, key_wdata_in = '0;
  logic [7:0] table_latch_out, memory_control_out;
  logic [1:0] tbl_mode_in = '0;
  logic [15:0] arr_rdata_in;
  logic nvm_done_flag_out, cpu_stall_out, arr_rd_out, arr_erase_out, arr_prog_out;
  logic [8*`HOLD_N-1:0] arr_wdata_out;
  logic [`HOLD_N-1:0] arr_byte_en_out;
  int failures = 0, n_compared = 0, n;
  flash_self_program_sequencer #(.PROG_CYCLES(PC)) dut (.*);
  flash_array_model mdl (.*);
  // ==========================================
  // Clock, compare and close
  initial forever #25 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Access tasks: k 0 ptr, 1 latch, 2 ctrl, 3 key, 4 read, 5 write, 6 done clear
  task automatic op(input int k, input logic [21:0] d);
    @(posedge clk_sys_in);
    {done_clr_in, tbl_wr_in, tbl_rd_in, key_wr_in, ctrl_wr_in, latch_wr_in, ptr_wr_in} <=
      7'(1 << k);
    ptr_wdata_in <= d;
    {latch_wdata_in, ctrl_wdata_in, key_wdata_in} <= {3{d[7:0]}};
    tbl_mode_in <= d[1:0];
    // Idle edge after each pulse keeps one driver step per signal
    @(posedge clk_sys_in);
    {done_clr_in, tbl_wr_in, tbl_rd_in, key_wr_in, ctrl_wr_in, latch_wr_in, ptr_wr_in} <= 7'h00;
  endtask
  function automatic logic [7:0] eb(input logic [7:0] a);
    eb = a[0] ? ~{1'b0, a[7:1]} : {1'b0, a[7:1]};
  endfunction
  task automatic rd(input logic [1:0] m, input logic [7:0] exp);
    op(4, 22'(m));
    @(posedge clk_sys_in);
    #1 chk(table_latch_out, exp);
  endtask
  // Keys then launch; returns just after the launch edge
  task automatic lw(input logic [7:0] c);
    op(3, 22'h55);
    op(3, 22'haa);
    op(2, 22'(c));
    #1;
  endtask
  task automatic nolaunch;
    @(posedge clk_sys_in);
    #1 chk(cpu_stall_out, 0);
  endtask
  task automatic run;
    n = 0;
    while (cpu_stall_out && n < 1000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    failures++;
    end_of_test;
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    por_in <= 0;
    #1 chk(arr_byte_en_out, 0);
    chk(&arr_wdata_out, 1);
    op(0, 22'h10);
    rd(2'b01, eb(8'h10));
    rd(2'b01, eb(8'h11));
    rd(2'b11, eb(8'h13));
    rd(2'b10, eb(8'h13));
    rd(2'b00, eb(8'h12));
    #1 chk(table_pointer_out, 22'h12);
    // Refused launches: no keys, broken keys, writes disabled
    op(2, 22'h86);
    nolaunch();
    op(3, 22'h55);
    op(0, 22'h7f);
    op(3, 22'haa);
    op(2, 22'h86);
    nolaunch();
    lw(8'h92);
    nolaunch();
    chk(memory_control_out[3], 1);
    // Erase block one with low pointer bits set
    lw(8'h96);
    chk(arr_erase_out, 1);
    chk(arr_addr_out, 22'h40);
    run();
    chk(n, PC);
    chk({memory_control_out[7], memory_control_out[4], memory_control_out[1]}, 3'b100);
    chk(nvm_done_flag_out, 1);
    op(6, 22'h0);
    #1 chk(nvm_done_flag_out, 0);
    op(0, 22'h3f);
    rd(2'b01, eb(8'h3f));
    rd(2'b01, 8'hff);
    // Partial block program from two holding bytes
    op(0, 22'h40);
    op(1, 22'h12);
    op(5, 22'h1);
    op(1, 22'h34);
    op(5, 22'h1);
    #1 chk(arr_byte_en_out, 64'h3);
    chk(arr_wdata_out[15:0], 16'h3412);
    lw(8'h86);
    chk(arr_prog_out, 1);
    chk(arr_addr_out, 22'h40);
    run();
    chk(n, PC);
    chk(arr_byte_en_out, 0);
    chk(&arr_wdata_out, 1);
    op(0, 22'h40);
    rd(2'b01, 8'h12);
    rd(2'b01, 8'h34);
    rd(2'b01, 8'hff);
    // Full block of zeros into block zero through 64 table writes
    op(1, 22'h0);
    op(0, 22'h0);
    for (int i = 0; i < `HOLD_N; i++) op(5, 22'h1);
    #1 chk(arr_byte_en_out, '1);
    chk(|arr_wdata_out, 0);
    chk(table_pointer_out, 22'h40);
    op(0, 22'h3e);
    lw(8'h86);
    chk(arr_addr_out, 22'h0);
    run();
    chk(n, PC);
    rd(2'b01, 8'h00);
    rd(2'b01, 8'h00);
    // Reset in the middle of a long write
    lw(8'h86);
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1;
    @(posedge clk_sys_in);
    sys_rst_in <= 0;
    #1 chk(memory_control_out[3], 1);
    chk(cpu_stall_out, 0);
    chk(memory_control_out[7], 1);
    // Let the checker see the edges just after the release
    repeat (3) @(posedge clk_sys_in);
    end_of_test;
  end
endmodule
